// ===== design/dgp_gpio.sv
/*
 * Dual general-purpose port with port B change detection.
 * Assumes an Avalon-MM master on clk_sys_in and external pad logic that
 * resolves each pin from the data, enable and pull-up outputs.
 */
// Implementation choice: the Avalon-MM interface to the registers.
// Functional notes
// - Port A bits 0-3 TTL I/O; bit 4 Schmitt timer clock input, open drain.
// - Unimplemented upper port A data and direction bits read as zero.
// - Port B is 8 bits; direction 1 is input, 0 drives the latch.
// - Option bit 7 cleared enables all port B weak pull-ups.
// - Pull-up of a port B output pin is always off.
// - Pull-ups are off after power-on reset.
// - Change detection covers port B pins 4-7 configured as inputs only.
// - Inputs are compared with a snapshot taken at the last port B read or write.
// - Mismatches are ORed and set the change flag at control bit 0.
// - A port change condition wakes the device from sleep.
// - Any port B read or write refreshes the snapshot, ending mismatch.
// - Only software clears the flag; a lasting mismatch keeps setting it.
// - Port B bit 0 is the external interrupt input, Schmitt when enabled.
// - Port B bits 6 and 7 are programming clock and data, Schmitt in mode.
// - Data reads return pin levels; writes load the whole output latch directly.
// - Port A direction 1 is input, 0 drives the latch onto the pin.
// - After power-on reset port A pins are inputs and the latch holds zero.
module dgp_gpio
    import dgp_pkg::*;
(
    // Clock, reset and enable
    input  wire logic                  clk_sys_in,
    input  wire logic                  sys_rst_in,
    input  wire logic                  clk_en_in,
    // Avalon-MM slave
    input  wire logic                  avs_read_in,
    input  wire logic                  avs_write_in,
    input  wire logic [DGP_ADDR_W-1:0] avs_address_in,
    input  wire logic [3:0]            avs_byteenable_in,
    input  wire logic [31:0]           avs_writedata_in,
    output logic      [31:0]           avs_readdata_out,
    output logic                       avs_waitrequest_out,
    output logic      [1:0]            avs_response_out,
    // Port A pins
    input  wire logic [DGP_PORT_A_W-1:0] port_a_pin_in,
    output logic      [DGP_PORT_A_W-1:0] port_a_pin_out,
    output logic      [DGP_PORT_A_W-1:0] port_a_pin_oe_out,
    output logic      [DGP_PORT_A_W-1:0] port_a_schmitt_out,
    // Port B pins
    input  wire logic [DGP_PORT_B_W-1:0] port_b_pin_in,
    output logic      [DGP_PORT_B_W-1:0] port_b_pin_out,
    output logic      [DGP_PORT_B_W-1:0] port_b_pin_oe_out,
    output logic      [DGP_PORT_B_W-1:0] port_b_pullup_out,
    output logic      [DGP_PORT_B_W-1:0] port_b_schmitt_out,
    // Alternate functions and events
    output logic                       a4_timer_clock_pin_out,
    output logic                       b0_ext_irq_pin_out,
    output logic                       prog_clk_out,
    output logic                       prog_data_out,
    output logic                       port_change_irq_out,
    output logic                       wake_out
);
    // ==========================================================
    // Register state
    // ==========================================================
    logic [DGP_PORT_A_W-1:0] port_a_latch_reg;
    logic [DGP_PORT_A_W-1:0] port_a_latch_next;
    logic [DGP_PORT_A_W-1:0] port_a_dir_reg;
    logic [DGP_PORT_A_W-1:0] port_a_dir_next;
    logic [DGP_PORT_B_W-1:0] port_b_latch_reg;
    logic [DGP_PORT_B_W-1:0] port_b_latch_next;
    logic [DGP_PORT_B_W-1:0] port_b_dir_reg;
    logic [DGP_PORT_B_W-1:0] port_b_dir_next;
    logic [7:0]              option_reg;
    logic [7:0]              option_next;
    logic [7:0]              intctrl_reg;
    logic [7:0]              intctrl_next;
    logic [2:0]              mode_reg;
    logic [2:0]              mode_next;
    logic [3:0]              snapshot_reg;
    logic [3:0]              snapshot_next;
    logic [31:0]             rdata_reg;
    logic [31:0]             rdata_next;
    logic [1:0]              resp_reg;
    logic [1:0]              resp_next;
    logic                    ack_reg;
    logic                    ack_next;

    logic [DGP_PORT_A_W-1:0] pa_sync;
    logic [DGP_PORT_B_W-1:0] pb_sync;
    logic [DGP_PORT_A_W-1:0] pa_pins;
    logic [DGP_PORT_B_W-1:0] pb_pins;

    logic [3:0]              mismatch;
    logic                    change_cond;
    logic [7:0]              wbyte;
    logic                    req;
    logic                    hit_b;
    dgp_bus_req_type         bus;

    // Register index of a word-aligned byte address.
    function automatic logic [7:0] reg_index(input logic [DGP_ADDR_W-1:0] addr);
        return addr[9:2];
    endfunction

    // True when the address maps onto a register.
    function automatic logic reg_mapped(input logic [7:0] idx);
        return (idx == DGP_IDX_PORT_A_DATA)
            || (idx == DGP_IDX_PORT_B_DATA)
            || (idx == DGP_IDX_INTERRUPT_CTRL)
            || (idx == DGP_IDX_INTERRUPT_CTRL_H)
            || (idx == DGP_IDX_OPTION_CONFIG)
            || (idx == DGP_IDX_PORT_A_DIR)
            || (idx == DGP_IDX_PORT_B_DIR)
            || (idx == DGP_IDX_MODE_CTRL);
    endfunction

    // ==========================================================
    // Pin input synchronisers
    // ==========================================================
    dgp_sync #(.WIDTH(DGP_PORT_A_W)) u_sync_a (
        .clk_sys_in (clk_sys_in),
        .sys_rst_in (sys_rst_in),
        .clk_en_in  (clk_en_in),
        .async_in   (port_a_pin_in),
        .sync_out   (pa_sync)
    );

    dgp_sync #(.WIDTH(DGP_PORT_B_W)) u_sync_b (
        .clk_sys_in (clk_sys_in),
        .sys_rst_in (sys_rst_in),
        .clk_en_in  (clk_en_in),
        .async_in   (port_b_pin_in),
        .sync_out   (pb_sync)
    );

    // ==========================================================
    // Pin drive
    // ==========================================================
    always_comb begin
        for (int i = 0; i < DGP_PORT_A_W; i++) begin
            if (i == DGP_A_TIMER_BIT) begin
                port_a_pin_out[i]    = 1'b0;
                port_a_pin_oe_out[i] = ~port_a_dir_reg[i] & ~port_a_latch_reg[i];
                port_a_schmitt_out[i] = 1'b1;
            end else begin
                port_a_pin_out[i]     = port_a_latch_reg[i];
                port_a_pin_oe_out[i]  = ~port_a_dir_reg[i];
                port_a_schmitt_out[i] = 1'b0;
            end
        end
    end

    assign port_b_pin_out    = port_b_latch_reg;
    assign port_b_pin_oe_out = ~port_b_dir_reg;

    // Pull-ups only on input pins with the active-low control cleared.
    assign port_b_pullup_out = port_b_dir_reg
                             & {DGP_PORT_B_W{~option_reg[DGP_OPT_PULLUP_BIT]}};

    always_comb begin
        port_b_schmitt_out = '0;

        port_b_schmitt_out[DGP_B_EXT_IRQ_BIT]  = mode_reg[DGP_MODE_EXTIRQ];
        port_b_schmitt_out[DGP_B_PROG_CLK_BIT] = mode_reg[DGP_MODE_PROG];
        port_b_schmitt_out[DGP_B_PROG_DAT_BIT] = mode_reg[DGP_MODE_PROG];
    end

    // Data reads see the synchronised pin levels, whether driven or not.
    assign pa_pins = pa_sync;
    assign pb_pins = pb_sync;

    assign a4_timer_clock_pin_out = pa_pins[DGP_A_TIMER_BIT];

    assign b0_ext_irq_pin_out = pb_pins[DGP_B_EXT_IRQ_BIT]
                              & mode_reg[DGP_MODE_EXTIRQ];
    assign prog_clk_out  = pb_pins[DGP_B_PROG_CLK_BIT] & mode_reg[DGP_MODE_PROG];
    assign prog_data_out = pb_pins[DGP_B_PROG_DAT_BIT] & mode_reg[DGP_MODE_PROG];

    // ==========================================================
    // Change detection
    // ==========================================================
    // Only input pins among the upper four take part.
    assign mismatch = (pb_pins[7:DGP_CHG_LO_BIT] ^ snapshot_reg)
                    & port_b_dir_reg[7:DGP_CHG_LO_BIT];
    assign change_cond = |mismatch;

    assign port_change_irq_out = intctrl_reg[DGP_IC_CHG_FLG_BIT]
                               & intctrl_reg[DGP_IC_CHG_EN_BIT]
                               & intctrl_reg[DGP_IC_GIE_BIT];

    assign wake_out = mode_reg[DGP_MODE_SLEEP] & change_cond;

    // ==========================================================
    // Avalon-MM slave
    // ==========================================================
    assign bus = '{
        read:       avs_read_in,
        write:      avs_write_in,
        address:    avs_address_in,
        byteenable: avs_byteenable_in,
        writedata:  avs_writedata_in
    };
    assign req   = (bus.read | bus.write) & ~ack_reg;
    assign hit_b = req
                 & (reg_index(bus.address) == DGP_IDX_PORT_B_DATA);

    assign wbyte = bus.writedata[7:0];

    assign avs_waitrequest_out = ~ack_reg;
    assign avs_readdata_out    = rdata_reg;
    assign avs_response_out    = resp_reg;

    always_comb begin
        port_a_latch_next = port_a_latch_reg;
        port_a_dir_next   = port_a_dir_reg;
        port_b_latch_next = port_b_latch_reg;
        port_b_dir_next   = port_b_dir_reg;
        option_next       = option_reg;
        intctrl_next      = intctrl_reg;
        mode_next         = mode_reg;
        snapshot_next     = snapshot_reg;

        rdata_next        = rdata_reg;
        resp_next         = resp_reg;
        ack_next          = req;
        if (req) begin
            rdata_next = '0;
            resp_next  = reg_mapped(reg_index(bus.address)) ? 2'h0 : 2'h2;
        end

        if (req && bus.read) begin
            unique case (reg_index(bus.address))
                DGP_IDX_PORT_A_DATA:      rdata_next[DGP_PORT_A_W-1:0] = pa_pins;
                DGP_IDX_PORT_B_DATA:      rdata_next[7:0] = pb_pins;
                DGP_IDX_INTERRUPT_CTRL,
                DGP_IDX_INTERRUPT_CTRL_H: rdata_next[7:0] = intctrl_reg;
                DGP_IDX_OPTION_CONFIG:    rdata_next[7:0] = option_reg;
                DGP_IDX_PORT_A_DIR:       rdata_next[DGP_PORT_A_W-1:0] = port_a_dir_reg;
                DGP_IDX_PORT_B_DIR:       rdata_next[7:0] = port_b_dir_reg;
                DGP_IDX_MODE_CTRL:        rdata_next[2:0] = mode_reg;
                default:                  rdata_next = '0;
            endcase
        end

        if (req && bus.write && bus.byteenable[0]) begin
            unique case (reg_index(bus.address))
                DGP_IDX_PORT_A_DATA: begin
                    // A whole-byte write replaces every latch bit.
                    port_a_latch_next = wbyte[DGP_PORT_A_W-1:0];
                end
                DGP_IDX_PORT_B_DATA:      port_b_latch_next = wbyte;
                DGP_IDX_INTERRUPT_CTRL,
                DGP_IDX_INTERRUPT_CTRL_H: intctrl_next = wbyte;
                DGP_IDX_OPTION_CONFIG:    option_next = wbyte;
                DGP_IDX_PORT_A_DIR:       port_a_dir_next = wbyte[DGP_PORT_A_W-1:0];
                DGP_IDX_PORT_B_DIR:       port_b_dir_next = wbyte;
                DGP_IDX_MODE_CTRL:        mode_next = wbyte[2:0];
                default:                  mode_next = mode_reg;
            endcase
        end

        // Any access to port B data reloads the snapshot.
        if (hit_b) begin
            snapshot_next = pb_pins[7:DGP_CHG_LO_BIT];
        end

        // Hardware set wins over a software clear in the same cycle.
        if (change_cond && !hit_b) begin
            intctrl_next[DGP_IC_CHG_FLG_BIT] = 1'b1;
        end
    end

    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            port_a_latch_reg <= '0;
            port_a_dir_reg   <= DGP_PORT_A_DIR_RST;
            port_b_latch_reg <= '0;
            port_b_dir_reg   <= DGP_PORT_B_DIR_RST;
            option_reg       <= DGP_OPTION_RST;
            intctrl_reg      <= DGP_INTCTRL_RST;
            mode_reg         <= DGP_MODE_RST;
            snapshot_reg     <= '0;

            rdata_reg        <= '0;
            resp_reg         <= '0;
            ack_reg          <= 1'b0;
        end else if (clk_en_in) begin
            port_a_latch_reg <= port_a_latch_next;
            port_a_dir_reg   <= port_a_dir_next;
            port_b_latch_reg <= port_b_latch_next;
            port_b_dir_reg   <= port_b_dir_next;
            option_reg       <= option_next;
            intctrl_reg      <= intctrl_next;
            mode_reg         <= mode_next;
            snapshot_reg     <= snapshot_next;

            rdata_reg        <= rdata_next;
            resp_reg         <= resp_next;
            ack_reg          <= ack_next;
        end
    end
endmodule

// ===== design/dgp_pkg.sv
/*
 * Constants and carrier types for the dual general-purpose port block.
 * Assumes a 32-bit Avalon-MM register bus with byte addresses.
 */
package dgp_pkg;

    // ==========================================================
    // Register indices and byte address width
    // ==========================================================
    localparam logic [7:0] DGP_IDX_PORT_A_DATA      = 8'h05;
    localparam logic [7:0] DGP_IDX_PORT_B_DATA      = 8'h06;
    localparam logic [7:0] DGP_IDX_INTERRUPT_CTRL   = 8'h0b;
    localparam logic [7:0] DGP_IDX_INTERRUPT_CTRL_H = 8'h8b;
    localparam logic [7:0] DGP_IDX_OPTION_CONFIG    = 8'h81;
    localparam logic [7:0] DGP_IDX_PORT_A_DIR       = 8'h85;
    localparam logic [7:0] DGP_IDX_PORT_B_DIR       = 8'h86;
    localparam logic [7:0] DGP_IDX_MODE_CTRL        = 8'hc0;
    localparam int         DGP_ADDR_W               = 10;

    // ==========================================================
    // Widths, fields and reset values
    // ==========================================================
    localparam int         DGP_PORT_A_W       = 5;
    localparam int         DGP_PORT_B_W       = 8;
    localparam int         DGP_A_TIMER_BIT    = 4;
    localparam int         DGP_B_EXT_IRQ_BIT  = 0;
    localparam int         DGP_B_PROG_CLK_BIT = 6;
    localparam int         DGP_B_PROG_DAT_BIT = 7;
    localparam int         DGP_CHG_LO_BIT     = 4;
    localparam int         DGP_OPT_PULLUP_BIT = 7;
    localparam int         DGP_IC_GIE_BIT     = 7;
    localparam int         DGP_IC_CHG_EN_BIT  = 3;
    localparam int         DGP_IC_CHG_FLG_BIT = 0;
    localparam int         DGP_MODE_EXTIRQ    = 0;
    localparam int         DGP_MODE_PROG      = 1;
    localparam int         DGP_MODE_SLEEP     = 2;
    localparam logic [7:0] DGP_OPTION_RST     = 8'hff;
    localparam logic [4:0] DGP_PORT_A_DIR_RST = 5'h1f;
    localparam logic [7:0] DGP_PORT_B_DIR_RST = 8'hff;
    localparam logic [7:0] DGP_INTCTRL_RST    = 8'h00;
    localparam logic [2:0] DGP_MODE_RST       = 3'h0;

    // ==========================================================
    // Carrier types
    // ==========================================================
    typedef struct packed {
        logic        read;
        logic        write;
        logic [9:0]  address;
        logic [3:0]  byteenable;
        logic [31:0] writedata;
    } dgp_bus_req_type;

    typedef struct packed {
        logic [7:0] data;
        logic [7:0] out_en;
        logic [7:0] pullup_en;
        logic [7:0] schmitt_en;
    } dgp_pin_drive_type;

endpackage

// ===== design/dgp_sync.sv
/*
 * Two-flip-flop synchroniser for a vector of pin inputs.
 * Assumes the pins are asynchronous to clk_sys_in.
 */
module dgp_sync #(
    parameter int WIDTH = 8
) (
    // Clock, reset and enable
    input  wire logic             clk_sys_in,
    input  wire logic             sys_rst_in,
    input  wire logic             clk_en_in,
    // Data
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1_reg;
    logic [WIDTH-1:0] stage2_reg;

    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            stage1_reg <= '0;
            stage2_reg <= '0;
        end else if (clk_en_in) begin
            stage1_reg <= async_in;
            stage2_reg <= stage1_reg;
        end
    end

    assign sync_out = stage2_reg;
endmodule

// ===== sim/dgp_gpio_props.sv
/* Checker for the dual port block, bound to every dgp_gpio instance.
   Assumes one clock domain and an active-high asynchronous reset. */
module dgp_gpio_props
    import dgp_pkg::*;
(
    // Clock and reset
    input wire logic                    clk_sys_in,
    input wire logic                    sys_rst_in,
    // Register bus
    input wire logic                    avs_read_in,
    input wire logic                    avs_write_in,
    input wire logic [DGP_ADDR_W-1:0]   avs_address_in,
    input wire logic [31:0]             avs_readdata_out,
    input wire logic                    avs_waitrequest_out,
    // Pins and events
    input wire logic [DGP_PORT_A_W-1:0] port_a_pin_out,
    input wire logic [DGP_PORT_A_W-1:0] port_a_pin_oe_out,
    input wire logic [DGP_PORT_A_W-1:0] port_a_schmitt_out,
    input wire logic [DGP_PORT_B_W-1:0] port_b_pin_oe_out,
    input wire logic [DGP_PORT_B_W-1:0] port_b_pullup_out,
    input wire logic [DGP_PORT_B_W-1:0] port_b_schmitt_out,
    input wire logic                    b0_ext_irq_pin_out,
    input wire logic                    prog_clk_out,
    input wire logic                    prog_data_out,
    input wire logic                    port_change_irq_out,
    input wire logic                    wake_out
);
    // ==========================================================
    // Assertions
    // ==========================================================
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (sys_rst_in);
    reset_values_a: assert property ($fell(sys_rst_in) |-> port_b_pullup_out == 8'h00
        && port_a_pin_oe_out == 5'h00 && port_b_pin_oe_out == 8'h00)
        else $error("bad reset outputs");
    answer_time_a: assert property ($rose(avs_read_in || avs_write_in) |=> !avs_waitrequest_out)
        else $error("answer not one cycle after request");
    single_answer_a: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
        else $error("waitrequest low too long");
    no_spurious_a: assert property (!(avs_read_in || avs_write_in) |=> avs_waitrequest_out)
        else $error("answer without request");
    output_pullup_a: assert property ((port_b_pullup_out & port_b_pin_oe_out) == 8'h00)
        else $error("pull-up on output pin");
    open_drain_a: assert property (port_a_pin_out[4] == 1'b0)
        else $error("bit 4 drives high");
    schmitt_a_a: assert property (port_a_schmitt_out == 5'h10) else $error("port a buffers");
    upper_zero_a: assert property (avs_read_in && !avs_waitrequest_out && avs_address_in ==
        {DGP_IDX_PORT_A_DATA, 2'b00} |-> avs_readdata_out[31:5] == 27'h0)
        else $error("upper bits");
    ext_irq_a: assert property (b0_ext_irq_pin_out |-> port_b_schmitt_out[0])
        else $error("ext irq without schmitt");
    prog_pins_a: assert property ((prog_clk_out || prog_data_out) |->
        port_b_schmitt_out[7:6] == 2'b11) else $error("prog pins without schmitt");
    read_c: cover property (avs_read_in && !avs_waitrequest_out);
    irq_c: cover property ($rose(port_change_irq_out));
    wake_c: cover property ($rose(wake_out));
endmodule

bind dgp_gpio dgp_gpio_props i_dgp_gpio_props (
    .clk_sys_in          (clk_sys_in),
    .sys_rst_in          (sys_rst_in),
    .avs_read_in         (avs_read_in),
    .avs_write_in        (avs_write_in),
    .avs_address_in      (avs_address_in),
    .avs_readdata_out    (avs_readdata_out),
    .avs_waitrequest_out (avs_waitrequest_out),
    .port_a_pin_out      (port_a_pin_out),
    .port_a_pin_oe_out   (port_a_pin_oe_out),
    .port_a_schmitt_out  (port_a_schmitt_out),
    .port_b_pin_oe_out   (port_b_pin_oe_out),
    .port_b_pullup_out   (port_b_pullup_out),
    .port_b_schmitt_out  (port_b_schmitt_out),
    .b0_ext_irq_pin_out  (b0_ext_irq_pin_out),
    .prog_clk_out        (prog_clk_out),
    .prog_data_out       (prog_data_out),
    .port_change_irq_out (port_change_irq_out),
    .wake_out            (wake_out)
);

// ===== sim/dgp_pad_model.sv
/* Pin-side model: pads, switches and wiring outside the port.
   Device drive and switch drive can both be on for one pin; device drive then wins. */
module dgp_pad_model #(
    parameter int W = 8
) (
    input  wire logic         clk_sys_in,
    input  wire logic [W-1:0] drv_in,
    input  wire logic [W-1:0] oe_in,
    input  wire logic [W-1:0] pu_in,
    input  wire logic [W-1:0] ext_en_in,
    input  wire logic [W-1:0] ext_in,
    output logic      [W-1:0] pin_out
);
    logic [W-1:0] last_reg = '0;
    // ==========================================================
    // Device drive wins, then a switch, then a pull-up; else the line toggles.
    // ==========================================================
    always @(posedge clk_sys_in) begin
        last_reg <= pin_out;
    end
    always_comb begin
        for (int i = 0; i < W; i++) begin
            pin_out[i] = oe_in[i] ? drv_in[i] : ext_en_in[i] ? ext_in[i] :
                         pu_in[i] ? 1'b1 : ~last_reg[i];
        end
    end
endmodule

// ===== sim/tb_top.sv
/* Self-checking bench for the dual port block over Avalon-MM.
   Assumes the pad model in sim/ and the checker bound to the design. */
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import dgp_pkg::*;
    localparam logic [9:0] A_DAT = {DGP_IDX_PORT_A_DATA, 2'b00};
    localparam logic [9:0] B_DAT = {DGP_IDX_PORT_B_DATA, 2'b00};
    localparam logic [9:0] INTC  = {DGP_IDX_INTERRUPT_CTRL, 2'b00};
    localparam logic [9:0] INTCH = {DGP_IDX_INTERRUPT_CTRL_H, 2'b00};
    localparam logic [9:0] OPT   = {DGP_IDX_OPTION_CONFIG, 2'b00};
    localparam logic [9:0] A_DIR = {DGP_IDX_PORT_A_DIR, 2'b00};
    localparam logic [9:0] B_DIR = {DGP_IDX_PORT_B_DIR, 2'b00};
    localparam logic [9:0] MODE  = {DGP_IDX_MODE_CTRL, 2'b00};
    logic        clk_sys = 1'b0, sys_rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
    logic [9:0]  avs_addr = 10'h000;
    logic [31:0] avs_wdata = 32'h0, avs_rdata, rd_val;
    logic [1:0]  avs_rsp, rsp_val;
    logic        avs_wait, t_clk, ext_irq, p_clk, p_dat, irq, wake;
    logic [4:0]  a_pin, a_out, a_oe, a_sch, a_ext_en = 5'h1f, a_ext = 5'h00;
    logic [7:0]  b_pin, b_out, b_oe, b_pu, b_sch, b_ext_en = 8'hff, b_ext = 8'h00;
    int          num_errors = 0, n_checks = 0;

    always #25 clk_sys = ~clk_sys;

    dgp_gpio i_dgp_gpio (.clk_sys_in(clk_sys), .sys_rst_in(sys_rst), .clk_en_in(1'b1),
        .avs_read_in(avs_read), .avs_write_in(avs_write), .avs_address_in(avs_addr),
        .avs_byteenable_in(4'hf), .avs_writedata_in(avs_wdata), .avs_readdata_out(avs_rdata),
        .avs_waitrequest_out(avs_wait), .avs_response_out(avs_rsp), .port_a_pin_in(a_pin),
        .port_a_pin_out(a_out), .port_a_pin_oe_out(a_oe), .port_a_schmitt_out(a_sch),
        .port_b_pin_in(b_pin), .port_b_pin_out(b_out), .port_b_pin_oe_out(b_oe),
        .port_b_pullup_out(b_pu), .port_b_schmitt_out(b_sch), .a4_timer_clock_pin_out(t_clk),
        .b0_ext_irq_pin_out(ext_irq), .prog_clk_out(p_clk), .prog_data_out(p_dat),
        .port_change_irq_out(irq), .wake_out(wake));
    dgp_pad_model #(.W(5)) i_dgp_pad_model_a (.clk_sys_in(clk_sys), .drv_in(a_out),
        .oe_in(a_oe), .pu_in(5'h00), .ext_en_in(a_ext_en), .ext_in(a_ext), .pin_out(a_pin));
    dgp_pad_model #(.W(8)) i_dgp_pad_model_b (.clk_sys_in(clk_sys), .drv_in(b_out),
        .oe_in(b_oe), .pu_in(b_pu), .ext_en_in(b_ext_en), .ext_in(b_ext), .pin_out(b_pin));

    // ==========================================================
    // Tasks
    // ==========================================================
    task automatic conclude;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [9:0] ad, input logic [7:0] wd);
        int n;
        avs_read <= ~wr;
        avs_write <= wr;
        avs_addr <= ad;
        avs_wdata <= {24'h0, wd};
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (avs_wait !== 1'b0 && n < 50);
        rd_val = avs_rdata;
        rsp_val = avs_rsp;
        if (n >= 50) begin
            num_errors++;
            conclude();
        end
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic wr(input logic [9:0] ad, input logic [7:0] d);
        bus(1'b1, ad, d);
    endtask
    task automatic rd(input logic [9:0] ad, input logic [31:0] exp);
        bus(1'b0, ad, 8'h00);
        chk(rd_val, exp);
    endtask
    task automatic settle;
        repeat (4) @(posedge clk_sys);
    endtask

    // ==========================================================
    // Main sequence; change detection is watched through the control register.
    // ==========================================================
    initial begin
        repeat (10) @(posedge clk_sys);
        sys_rst <= 1'b0;
        @(posedge clk_sys);
        chk(b_pu, 8'h00);
        chk(a_oe, 5'h00);
        rd(OPT, 32'hff);
        rd(A_DIR, 32'h1f);
        rd(B_DIR, 32'hff);
        rd(INTC, 32'h00);
        rd(A_DAT, 32'h00);
        a_ext <= 5'h10;
        wr(A_DAT, 8'h0a);
        wr(A_DIR, 8'he0);
        rd(A_DIR, 32'h00);
        rd(A_DAT, 32'h0a);
        chk(a_oe, 5'h1f);
        wr(A_DAT, 8'h15);
        rd(A_DAT, 32'h15);
        chk(a_oe, 5'h0f);
        chk(a_out, 5'h05);
        chk(t_clk, 1'b1);
        wr(A_DIR, 8'hff);
        rd(A_DIR, 32'h1f);
        b_ext <= 8'h3c;
        wr(B_DIR, 8'hf0);
        wr(B_DAT, 8'ha5);
        rd(B_DAT, 32'h35);
        chk({b_oe, b_out}, 16'h0fa5);
        wr(OPT, 8'h7f);
        chk(b_pu, 8'hf0);
        b_ext_en <= 8'h0f;
        settle();
        rd(B_DAT, 32'hf5);
        wr(OPT, 8'hff);
        chk(b_pu, 8'h00);
        b_ext_en <= 8'hff;
        b_ext <= 8'h50;
        wr(B_DIR, 8'hff);
        settle();
        rd(B_DAT, 32'h50);
        wr(INTC, 8'h88);
        b_ext <= 8'h5f;
        settle();
        rd(INTC, 32'h88);
        wr(B_DIR, 8'h70);
        settle();
        rd(INTC, 32'h88);
        wr(B_DIR, 8'hff);
        b_ext <= 8'h4f;
        settle();
        rd(INTC, 32'h89);
        chk(irq, 1'b1);
        wr(INTC, 8'h88);
        rd(INTC, 32'h89);
        wr(MODE, 8'h04);
        chk(wake, 1'b1);
        wr(INTC, 8'h08);
        chk(irq, 1'b0);
        rd(B_DAT, 32'h4f);
        chk(wake, 1'b0);
        wr(INTC, 8'h88);
        rd(INTCH, 32'h88);
        chk(irq, 1'b0);
        b_ext <= 8'h0f;
        settle();
        wr(B_DAT, 8'h00);
        wr(INTC, 8'h88);
        rd(INTC, 32'h88);
        wr(MODE, 8'h01);
        b_ext <= 8'hc1;
        settle();
        chk({b_sch, ext_irq, p_clk, p_dat}, 11'h00c);
        wr(MODE, 8'h02);
        chk({b_sch, ext_irq, p_clk, p_dat}, 11'h603);
        chk(a_sch, 5'h10);
        rd(10'h3fc, 32'h0);
        chk(rsp_val, 2'b10);
        conclude();
    end
endmodule
